// ---- rtl/sdb_pkg.sv ----
// Shared constants and types for the strobe and trigger debounce block
package sdb_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int GPIO_N = 4;
	localparam int SRC_W = 2;
	localparam int CNT_W = 24;
	localparam int DEB_W = 16;
	localparam int SKIP_W = 12;
	localparam int PAT_N = 16;
	localparam int PIDX_W = 4;
	localparam int ADDR_W = 12;

	localparam logic [CNT_W-1:0] CNT_ONE = 24'h00_0001;
	localparam logic [DEB_W-1:0] DEB_ONE = 16'h0001;
	localparam logic [SKIP_W-1:0] SKIP_ONE = 12'h001;
	localparam logic [PIDX_W-1:0] PIDX_ONE = 4'h1;

	// Default trigger rejection width, in pixel-clock ticks
	localparam logic [DEB_W-1:0] DEB_DEFAULT = 16'h0010;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] REG_CTRL = 12'h000;
	localparam logic [ADDR_W-1:0] REG_GPIO_MODE = 12'h004;
	localparam logic [ADDR_W-1:0] REG_GPIO_DATA = 12'h008;
	localparam logic [ADDR_W-1:0] REG_STB_DELAY = 12'h00c;
	localparam logic [ADDR_W-1:0] REG_STB_DUR = 12'h010;
	localparam logic [ADDR_W-1:0] REG_SHUTTER = 12'h014;
	localparam logic [ADDR_W-1:0] REG_FRAME = 12'h018;
	localparam logic [ADDR_W-1:0] REG_DEB_WIDTH = 12'h01c;
	localparam logic [ADDR_W-1:0] REG_PATTERN = 12'h020;
	localparam logic [ADDR_W-1:0] REG_SKIP = 12'h024;
	localparam logic [ADDR_W-1:0] REG_STATUS = 12'h028;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_TRIG_ON = 0;
	localparam int CTRL_POL = 1;
	localparam int CTRL_DEB_EN = 2;
	localparam int CTRL_SRC_LSB = 4;
	localparam int CTRL_MODE_LSB = 8;
	localparam int PAT_LAST_LSB = 16;
	localparam int ST_EXPOSING = 0;
	localparam int ST_STROBE = 1;
	localparam int ST_PINS_LSB = 4;
	localparam int ST_PIDX_LSB = 8;
	localparam int ST_TCNT_LSB = 16;

	localparam logic [PAT_N-1:0] RST_PAT_MASK = 16'hffff;

	// ----------------------------------------------------------------
	// Modes and states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		GPIO_IN = 2'b00,
		GPIO_OUT = 2'b01,
		GPIO_TRIG = 2'b10,
		GPIO_STROBE = 2'b11
	} sdb_gpio_mode_t;

	localparam logic [3:0] TRIG_STD = 4'h0;
	localparam logic [3:0] TRIG_SKIP = 4'h3;

	typedef enum logic [1:0] {
		STB_IDLE = 2'b00,
		STB_WAIT = 2'b01,
		STB_PULSE = 2'b10
	} sdb_stb_state_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ADDR_W-1:0] paddr;
		logic [31:0] pwdata;
	} sdb_apb_req_t;

endpackage : sdb_pkg

// ---- rtl/sdb_debounce.sv ----
// Trigger pulse-width filter counting pixel-clock ticks
`timescale 1ns/1ns
`default_nettype none
module sdb_debounce
	import sdb_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	input wire logic i_tick,
	input wire logic i_level,
	input wire logic [DEB_W-1:0] i_width,
	output logic o_level
);

	typedef struct packed {
		logic level;
		logic [DEB_W-1:0] cnt;
	} sdb_deb_st_t;

	sdb_deb_st_t st;
	sdb_deb_st_t next_st;
	logic [DEB_W-1:0] need;

	// A change passes only after holding for the full width
	always_comb
	begin
		next_st = st;
		need = (i_width == '0) ? DEB_ONE : i_width;
		if (i_level == st.level)
			next_st.cnt = '0;
		else if (i_tick)
		begin
			if (st.cnt >= need - DEB_ONE)
			begin
				next_st.level = i_level;
				next_st.cnt = '0;
			end
			else
				next_st.cnt = st.cnt + DEB_ONE;
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		// Idle pin sits at its pull-up, so no false edge follows reset
		if (i_sys_rst)
			st <= '{level: 1'b1, cnt: '0};
		else
			st <= next_st;
	end

	assign o_level = st.level;

	deb_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		$changed(o_level) |-> ($past(i_level) == o_level)
		&& ($past(st.cnt) >= $past(need) - DEB_ONE))
		else $error("filtered level moved before width elapsed");

endmodule : sdb_debounce
`default_nettype wire

// ---- rtl/sdb_strobe_timer.sv ----
// Strobe offset and width timer
`timescale 1ns/1ns
`default_nettype none
module sdb_strobe_timer
	import sdb_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	input wire logic i_tick,
	input wire logic i_start,
	input wire logic [CNT_W-1:0] i_delay,
	input wire logic [CNT_W-1:0] i_duration,
	input wire logic [CNT_W-1:0] i_shutter,
	output logic o_strobe
);

	typedef struct packed {
		sdb_stb_state_t state;
		logic [CNT_W-1:0] cnt;
		logic strobe;
	} sdb_stb_st_t;

	sdb_stb_st_t st;
	sdb_stb_st_t next_st;
	logic [CNT_W-1:0] width;

	// Enter the pulse phase; a zero width gives no pulse at all
	function automatic sdb_stb_st_t begin_pulse(logic [CNT_W-1:0] w);
		sdb_stb_st_t r;
		r.state = (w == '0) ? STB_IDLE : STB_PULSE;
		r.cnt = w;
		r.strobe = (w != '0);
		return r;
	endfunction : begin_pulse

	// Zero duration follows the exposure time
	always_comb
	begin
		width = (i_duration == '0) ? i_shutter : i_duration;
		next_st = st;
		if (i_start)
		begin
			if (i_delay == '0)
				next_st = begin_pulse(width);
			else
			begin
				next_st.state = STB_WAIT;
				next_st.cnt = i_delay;
				next_st.strobe = 1'b0;
			end
		end
		else if (i_tick)
		begin
			unique case (st.state)
				STB_IDLE: next_st.strobe = 1'b0;
				STB_WAIT:
				begin
					if (st.cnt == CNT_ONE)
						next_st = begin_pulse(width);
					else
						next_st.cnt = st.cnt - CNT_ONE;
				end
				STB_PULSE:
				begin
					if (st.cnt == CNT_ONE)
					begin
						next_st.state = STB_IDLE;
						next_st.strobe = 1'b0;
					end
					else
						next_st.cnt = st.cnt - CNT_ONE;
				end
				default:
				begin
					next_st.state = STB_IDLE;
					next_st.strobe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
			st <= '0;
		else
			st <= next_st;
	end

	assign o_strobe = st.strobe;

	stb_prompt_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		i_start && (i_delay == '0) && (width != '0) |=> o_strobe)
		else $error("zero-offset strobe did not start next cycle");

endmodule : sdb_strobe_timer
`default_nettype wire

// ---- rtl/sdb_strobe_trigger.sv ----
// Strobe generator, trigger filter and APB registers: top level
//
// What this block does
// - Strobe pulses go only to GPIO pins configured as outputs.
// - Strobe starts after programmed offset from exposure start or trigger.
// - By default every exposure start gives one strobe pulse.
// - Strobe width is programmed; zero width means exposure time.
// - Several strobe-mode pins pulse together.
// - A pattern selects which frames produce a strobe.
// - Filter disabled: trigger pulses under 16 ticks are dropped.
// - Filter enabled: pulses under programmed width are dropped.
// - Programmed filtering applies only to pins in input mode.
// - Filtering applies in every trigger mode but skip frames.
// - Filtering delays the trigger by the filter width.
// - Strobe-mode pin pulses at fixed delay from integration or trigger.
// - Input-mode pins accept external trigger signals.
// - Skip frames mode triggers internally every N frame periods.
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module sdb_strobe_trigger
	import sdb_pkg::*;
#(
	parameter int PIX_DIV = 1,
	parameter logic [CNT_W-1:0] FRAME_TICKS = 24'h00_c350,
	parameter logic [CNT_W-1:0] SHUTTER_TICKS = 24'h00_2710
)
(
	input wire logic i_sys_clk,
	input wire logic i_sys_rst,
	input wire sdb_apb_req_t i_apb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic [GPIO_N-1:0] i_gpio_in,
	output logic [GPIO_N-1:0] o_gpio_out,
	output logic [GPIO_N-1:0] o_gpio_oe,
	output logic o_exposing
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [GPIO_N-1:0] sync1;
		logic [GPIO_N-1:0] sync2;
		logic [GPIO_N-1:0] sync3;
		logic [GPIO_N-1:0] pin_level;
		logic trig_on;
		logic trig_pol;
		logic deb_en;
		logic [SRC_W-1:0] trig_src;
		logic [3:0] trig_mode;
		logic [GPIO_N-1:0][1:0] gpio_mode;
		logic [GPIO_N-1:0] gpio_data;
		logic [CNT_W-1:0] stb_delay;
		logic [CNT_W-1:0] stb_dur;
		logic [CNT_W-1:0] shutter;
		logic [CNT_W-1:0] frame_period;
		logic [DEB_W-1:0] deb_width;
		logic [PAT_N-1:0] pat_mask;
		logic [PIDX_W-1:0] pat_last;
		logic [SKIP_W-1:0] skip_n;
		logic [15:0] div_cnt;
		logic [CNT_W-1:0] frame_cnt;
		logic [CNT_W-1:0] exp_cnt;
		logic exposing;
		logic [SKIP_W-1:0] skip_cnt;
		logic [PIDX_W-1:0] pat_idx;
		logic trig_prev;
		logic [15:0] trig_count;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [GPIO_N-1:0] gpio_out;
		logic [GPIO_N-1:0] gpio_oe;
	} sdb_top_st_t;

	localparam sdb_top_st_t ST_RST = '{
		sync1: '1,
		sync2: '1,
		sync3: '1,
		pin_level: '1,
		pat_mask: RST_PAT_MASK,
		frame_period: FRAME_TICKS,
		shutter: SHUTTER_TICKS,
		deb_width: DEB_DEFAULT,
		skip_n: SKIP_ONE,
		default: '0
	};
	localparam logic [15:0] DIV_LAST = 16'(PIX_DIV - 1);

	sdb_top_st_t st;
	sdb_top_st_t next_st;

	logic tick;
	logic access;
	logic [1:0] src_mode;
	logic src_ok;
	logic [DEB_W-1:0] deb_need;
	logic deb_level;
	logic trig_act;
	logic trig_edge;
	logic frame_pulse;
	logic exp_start;
	logic stb_fire;
	logic stb_start;
	logic strobe;

	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------
	sdb_debounce u_debounce (
		.i_sys_clk(i_sys_clk),
		.i_sys_rst(i_sys_rst),
		.i_tick(tick),
		.i_level(st.pin_level[st.trig_src]),
		.i_width(deb_need),
		.o_level(deb_level)
	);

	sdb_strobe_timer u_strobe (
		.i_sys_clk(i_sys_clk),
		.i_sys_rst(i_sys_rst),
		.i_tick(tick),
		.i_start(stb_start),
		.i_delay(st.stb_delay),
		.i_duration(st.stb_dur),
		.i_shutter(st.shutter),
		.o_strobe(strobe)
	);

	// ----------------------------------------------------------------
	// Trigger path and frame timing
	// ----------------------------------------------------------------

	// Pixel tick and trigger qualification
	always_comb
	begin
		tick = (st.div_cnt == '0);
		src_mode = st.gpio_mode[st.trig_src];
		src_ok = (src_mode == GPIO_IN) || (src_mode == GPIO_TRIG);
		// Programmed width only on an input-mode pin; else the fixed 16
		if (st.deb_en && (src_mode == GPIO_IN))
			deb_need = st.deb_width;
		else
			deb_need = DEB_DEFAULT;
		trig_act = src_ok && (deb_level == st.trig_pol);
		trig_edge = trig_act && !st.trig_prev;
		frame_pulse = tick && (st.frame_cnt >= st.frame_period - CNT_ONE);
	end

	// Exposure start source per trigger mode
	always_comb
	begin
		if (!st.trig_on)
			exp_start = frame_pulse; // free running
		else if (st.trig_mode == TRIG_SKIP)
			exp_start = frame_pulse && (st.skip_cnt == '0);
		else
			exp_start = trig_edge && !st.exposing;
		stb_fire = st.pat_mask[st.pat_idx];
		stb_start = exp_start && stb_fire;
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_st = st;
		access = i_apb.psel && i_apb.penable;

		// Pin synchroniser: accept a change once stages two and three agree
		next_st.sync1 = i_gpio_in;
		next_st.sync2 = st.sync1;
		next_st.sync3 = st.sync2;
		next_st.pin_level = (st.sync2 & st.sync3)
			| (st.pin_level & (st.sync2 | st.sync3));

		// Pixel-clock divider
		next_st.div_cnt = (st.div_cnt >= DIV_LAST) ? '0
			: st.div_cnt + 16'h0001;

		// Frame timer runs free; it also paces skip frames
		if (tick)
			next_st.frame_cnt = frame_pulse ? '0 : st.frame_cnt + CNT_ONE;
		if (frame_pulse && st.trig_on && (st.trig_mode == TRIG_SKIP))
		begin
			if (st.skip_cnt == '0)
				next_st.skip_cnt = (st.skip_n == '0) ? '0
					: st.skip_n - SKIP_ONE;
			else
				next_st.skip_cnt = st.skip_cnt - SKIP_ONE;
		end

		// Trigger edge history; counts external trigger edges, including those dropped during exposure
		next_st.trig_prev = trig_act;
		if (trig_edge && st.trig_on && (st.trig_mode != TRIG_SKIP))
			next_st.trig_count = st.trig_count + 16'h0001;

		// Exposure window; triggers during it are dropped
		if (exp_start)
		begin
			next_st.exposing = (st.shutter != '0);
			next_st.exp_cnt = st.shutter;
			next_st.pat_idx = (st.pat_idx >= st.pat_last) ? '0
				: st.pat_idx + PIDX_ONE;
		end
		else if (tick && st.exposing)
		begin
			if (st.exp_cnt == CNT_ONE)
				next_st.exposing = 1'b0;
			next_st.exp_cnt = st.exp_cnt - CNT_ONE;
		end

		// Pin drivers: strobe reaches every strobe-mode pin at once
		for (int i = 0; i < GPIO_N; i++)
		begin
			next_st.gpio_out[i] = 1'b0;
			next_st.gpio_oe[i] = 1'b0;
			if (st.gpio_mode[i] == GPIO_OUT)
			begin
				next_st.gpio_out[i] = st.gpio_data[i];
				next_st.gpio_oe[i] = 1'b1;
			end
			else if (st.gpio_mode[i] == GPIO_STROBE)
			begin
				next_st.gpio_out[i] = strobe;
				next_st.gpio_oe[i] = 1'b1;
			end
		end

		// APB: one wait state, then a single-cycle answer
		next_st.pready = access && !st.pready;
		next_st.pslverr = 1'b0;
		if (access && !st.pready)
		begin
			next_st.prdata = '0;
			case (i_apb.paddr)
				REG_CTRL: next_st.prdata = {20'h0_0000, st.trig_mode,
					2'b00, st.trig_src, 1'b0, st.deb_en, st.trig_pol,
					st.trig_on};
				REG_GPIO_MODE: next_st.prdata = 32'(st.gpio_mode);
				REG_GPIO_DATA: next_st.prdata = 32'(st.gpio_data);
				REG_STB_DELAY: next_st.prdata = 32'(st.stb_delay);
				REG_STB_DUR: next_st.prdata = 32'(st.stb_dur);
				REG_SHUTTER: next_st.prdata = 32'(st.shutter);
				REG_FRAME: next_st.prdata = 32'(st.frame_period);
				REG_DEB_WIDTH: next_st.prdata = 32'(st.deb_width);
				REG_PATTERN: next_st.prdata = {12'h000, st.pat_last,
					st.pat_mask};
				REG_SKIP: next_st.prdata = 32'(st.skip_n);
				REG_STATUS:
				begin
					next_st.prdata[ST_EXPOSING] = st.exposing;
					next_st.prdata[ST_STROBE] = strobe;
					next_st.prdata[ST_PINS_LSB +: GPIO_N] = st.pin_level;
					next_st.prdata[ST_PIDX_LSB +: PIDX_W] = st.pat_idx;
					next_st.prdata[ST_TCNT_LSB +: 16] = st.trig_count;
				end
				default: next_st.pslverr = 1'b1;
			endcase
		end

		// Writes land at the edge where the master sees pready
		if (access && st.pready && i_apb.pwrite)
		begin
			case (i_apb.paddr)
				REG_CTRL:
				begin
					next_st.trig_on = i_apb.pwdata[CTRL_TRIG_ON];
					next_st.trig_pol = i_apb.pwdata[CTRL_POL];
					next_st.deb_en = i_apb.pwdata[CTRL_DEB_EN];
					next_st.trig_src = i_apb.pwdata[CTRL_SRC_LSB +: SRC_W];
					next_st.trig_mode = i_apb.pwdata[CTRL_MODE_LSB +: 4];
					next_st.skip_cnt = '0;
				end
				REG_GPIO_MODE: next_st.gpio_mode = i_apb.pwdata[2*GPIO_N-1:0];
				REG_GPIO_DATA: next_st.gpio_data = i_apb.pwdata[GPIO_N-1:0];
				REG_STB_DELAY: next_st.stb_delay = i_apb.pwdata[CNT_W-1:0];
				REG_STB_DUR: next_st.stb_dur = i_apb.pwdata[CNT_W-1:0];
				REG_SHUTTER: next_st.shutter = i_apb.pwdata[CNT_W-1:0];
				REG_FRAME: next_st.frame_period = i_apb.pwdata[CNT_W-1:0];
				REG_DEB_WIDTH: next_st.deb_width = i_apb.pwdata[DEB_W-1:0];
				REG_PATTERN:
				begin
					next_st.pat_mask = i_apb.pwdata[PAT_N-1:0];
					next_st.pat_last = i_apb.pwdata[PAT_LAST_LSB +: PIDX_W];
					next_st.pat_idx = '0;
				end
				REG_SKIP: next_st.skip_n = i_apb.pwdata[SKIP_W-1:0];
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Registers and outputs
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk)
	begin
		if (i_sys_rst)
			st <= ST_RST;
		else
			st <= next_st;
	end

	assign o_prdata = st.prdata;
	assign o_pready = st.pready;
	assign o_pslverr = st.pslverr;
	assign o_gpio_out = st.gpio_out;
	assign o_gpio_oe = st.gpio_oe;
	assign o_exposing = st.exposing;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic pin0_input;
	logic pins_strobe;
	assign pin0_input = (st.gpio_mode[0] == GPIO_IN);
	assign pins_strobe = (st.gpio_mode[1] == GPIO_STROBE)
		&& (st.gpio_mode[2] == GPIO_STROBE);

	apb_wait_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		access && !o_pready |=> o_pready ##1 !o_pready)
		else $error("apb answer not one cycle after wait");

	apb_err_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		o_pslverr |-> o_pready)
		else $error("slave error without pready");

	pin_oe_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		$past(pin0_input) |-> !o_gpio_oe[0])
		else $error("input-mode pin is driven");

	strobe_pins_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		$past(pins_strobe) |-> (o_gpio_out[1] == o_gpio_out[2]))
		else $error("strobe pins differ");

	skip_ignore_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		st.trig_on && (st.trig_mode == TRIG_SKIP) && !frame_pulse
		|=> !$rose(st.exposing))
		else $error("skip mode started exposure off frame boundary");

	trig_start_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		st.trig_on && (st.trig_mode == TRIG_STD) && trig_edge
		&& !st.exposing && (st.shutter != '0) |=> st.exposing)
		else $error("trigger did not start exposure");

	pat_wrap_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		exp_start && (st.pat_idx >= st.pat_last) |=> (st.pat_idx == '0))
		else $error("pattern index failed to wrap");

	pat_gate_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		exp_start && !stb_fire && !strobe && (u_strobe.st.state == STB_IDLE)
		|=> !strobe)
		else $error("masked frame produced a strobe");

endmodule : sdb_strobe_trigger
`default_nettype wire

// ---- verification/sdb_pin_model.sv ----
// Far-side model: trigger source and strobed lamp on the GPIO pins
`timescale 1ns/1ns
`default_nettype none
module sdb_pin_model
	import sdb_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic [GPIO_N-1:0] i_out,
	input wire logic [GPIO_N-1:0] i_oe,
	output logic [GPIO_N-1:0] o_pin
);
	logic [GPIO_N-1:0] pull_low = '0;
	logic lamp_q = 1'b0;
	int n_stb = 0;

	// ----------------------------------------------------------------
	// Pin level
	// ----------------------------------------------------------------
	// Undriven pins float to the pull-up, so an idle pin reads high
	assign o_pin = (i_oe & i_out) | (~i_oe & ~pull_low);

	// Lamp on pin 1 counts flashes; an undriven pin cannot light it
	always @(posedge i_sys_clk)
	begin
		lamp_q <= i_oe[1] & i_out[1];
		if ((i_oe[1] & i_out[1]) && !lamp_q)
			n_stb <= n_stb + 1;
	end

	// Active-low trigger: short pin p to ground for w cycles
	task automatic pulse(input int p, input int w);
		@(posedge i_sys_clk);
		pull_low[p] <= 1'b1;
		repeat (w) @(posedge i_sys_clk);
		pull_low[p] <= 1'b0;
	endtask : pulse
endmodule : sdb_pin_model
`default_nettype wire

// ---- verification/tb_strobe_and_trigger_debounce.sv ----
// Self-checking testbench for the strobe and trigger filter block
`timescale 1ns/1ns
`default_nettype none
module tb_strobe_and_trigger_debounce
	import sdb_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	// Short frame and shutter keep the run brief
	localparam logic [CNT_W-1:0] FT = 24'h00_0040;
	localparam logic [CNT_W-1:0] ST = 24'h00_0008;
	logic i_sys_clk;
	logic i_sys_rst;
	sdb_apb_req_t apb;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [GPIO_N-1:0] pin;
	logic [GPIO_N-1:0] gout;
	logic [GPIO_N-1:0] goe;
	logic expo;
	logic [31:0] q;
	logic e;
	int n_fail = 0;
	int compares = 0;
	int cyc = 0;
	int la;
	int lb;

	sdb_strobe_trigger #(.PIX_DIV(1), .FRAME_TICKS(FT), .SHUTTER_TICKS(ST))
		dut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_apb(apb),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_gpio_in(pin), .o_gpio_out(gout), .o_gpio_oe(goe),
		.o_exposing(expo));

	sdb_pin_model m (.i_sys_clk(i_sys_clk), .i_out(gout), .i_oe(goe),
		.o_pin(pin));

	// ----------------------------------------------------------------
	// Common tasks
	// ----------------------------------------------------------------
	task automatic stop_test;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// One APB transfer; request held until pready is sampled high
	task automatic xfer(input logic wr, input logic [ADDR_W-1:0] ad,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge i_sys_clk);
		apb.psel <= 1'b1;
		apb.penable <= 1'b0;
		apb.pwrite <= wr;
		apb.paddr <= ad;
		apb.pwdata <= d;
		@(posedge i_sys_clk);
		apb.penable <= 1'b1;
		do
		begin
			@(posedge i_sys_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		q = prdata;
		e = pslverr;
		apb.psel <= 1'b0;
		apb.penable <= 1'b0;
		check({31'h0, pready}, 32'h1);
	endtask : xfer

	// Wait for the next rising edge of the exposure window
	task automatic rise;
		int n;
		n = 0;
		while (expo !== 1'b0 && n < 400)
		begin
			@(posedge i_sys_clk);
			n++;
		end
		while (expo !== 1'b1 && n < 400)
		begin
			@(posedge i_sys_clk);
			n++;
		end
		if (n >= 400)
			n_fail++;
	endtask : rise

	// Trigger pulse on pin 0; lat 150 means no exposure followed
	task automatic trig(input int w, output int lat);
		lat = 0;
		fork
			m.pulse(0, w);
			while (expo !== 1'b1 && lat < 150)
			begin
				@(posedge i_sys_clk);
				lat++;
			end
		join
		repeat (40) @(posedge i_sys_clk);
	endtask : trig

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		xfer(1'b0, REG_STB_DUR, 32'h0);
		check(q, 32'h0);
		xfer(1'b0, REG_SHUTTER, 32'h0);
		check(q, 32'(ST));
		xfer(1'b0, REG_DEB_WIDTH, 32'h0);
		check(q, 32'(DEB_DEFAULT));
		xfer(1'b0, REG_PATTERN, 32'h0);
		check(q, 32'h0000_ffff);
		xfer(1'b0, 12'h100, 32'h0);
		check({31'h0, e}, 32'h1);
		check(q, 32'h0);
	endtask : t_reset

	// Pins 1 and 2 strobe together, offset 3, width shutter then 5
	task automatic t_strobe;
		int n;
		xfer(1'b1, REG_GPIO_MODE, 32'h0000_007c);
		xfer(1'b1, REG_GPIO_DATA, 32'h0000_0008);
		xfer(1'b1, REG_STB_DELAY, 32'h0000_0003);
		for (int k = 0; k < 2; k++)
		begin
			xfer(1'b1, REG_STB_DUR, 32'(k * 5));
			rise();
			n = 0;
			while (gout[1] !== 1'b1 && n < 100)
			begin
				@(posedge i_sys_clk);
				n++;
			end
			check(32'(n), 32'h4);
			check({28'h0, gout}, 32'he);
			check({28'h0, goe}, 32'he);
			n = 0;
			while (gout[1] === 1'b1 && n < 100)
			begin
				@(posedge i_sys_clk);
				n++;
			end
			check(32'(n), (k == 0) ? 32'(ST) : 32'h5);
		end
	endtask : t_strobe

	// Default, every 2nd, last 3 of 6, frames 1 5 7 of 8
	task automatic t_pattern;
		logic [31:0] pat [4] = '{32'h0000_ffff, 32'h0003_0005,
			32'h0005_0038, 32'h0007_00a2};
		int fr [4] = '{4, 8, 6, 8};
		int ex [4] = '{4, 4, 3, 3};
		int s;
		for (int i = 0; i < 4; i++)
		begin
			rise();
			repeat (20) @(posedge i_sys_clk);
			xfer(1'b1, REG_PATTERN, pat[i]);
			s = m.n_stb;
			repeat (fr[i]) rise();
			repeat (20) @(posedge i_sys_clk);
			check(32'(m.n_stb - s), 32'(ex[i]));
		end
	endtask : t_pattern

	// External trigger, active low, on pin 0
	task automatic t_filter;
		int lat;
		xfer(1'b1, REG_CTRL, 32'h0000_0001);
		repeat (80) @(posedge i_sys_clk);
		trig(15, lat);
		check(32'(lat < 150), 32'h0);
		trig(16, la);
		check(32'(la < 150), 32'h1);
		// Width above the longest rejected glitch
		xfer(1'b1, REG_DEB_WIDTH, 32'h0000_001e);
		xfer(1'b1, REG_CTRL, 32'h0000_0005);
		trig(29, lat);
		check(32'(lat < 150), 32'h0);
		trig(30, lb);
		check(32'(lb < 150), 32'h1);
		check(32'(lb - la), 32'he);
		xfer(1'b1, REG_GPIO_MODE, 32'h0000_003e);
		trig(20, lat);
		check(32'(lat < 150), 32'h1);
	endtask : t_filter

	// Skip mode: internal trigger every 2 frames, pin pulse ignored
	task automatic t_skip;
		int n;
		logic pv;
		xfer(1'b1, REG_SKIP, 32'h0000_0002);
		xfer(1'b1, REG_CTRL, 32'h0000_0301);
		rise();
		n = 0;
		pv = 1'b1;
		fork
			m.pulse(0, 40);
			while (n < 400 && !(expo === 1'b1 && pv === 1'b0))
			begin
				pv = expo;
				@(posedge i_sys_clk);
				n++;
			end
		join
		check(32'(n), 32'(2 * FT));
	endtask : t_skip

	// ----------------------------------------------------------------
	// Clock, timeout and main sequence
	// ----------------------------------------------------------------
	initial
	begin
		i_sys_clk = 1'b0;
		forever #10 i_sys_clk = ~i_sys_clk;
	end

	// Whole run needs about 3000 cycles
	always @(posedge i_sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_fail++;
			stop_test();
		end
	end

	initial
	begin
		i_sys_rst = 1'b1;
		apb = '0;
		repeat (4) @(posedge i_sys_clk);
		i_sys_rst <= 1'b0;
		t_reset();
		t_strobe();
		t_pattern();
		t_filter();
		t_skip();
		stop_test();
	end
endmodule : tb_strobe_and_trigger_debounce
`default_nettype wire
